/* vaddsub_consts.vh */
`ifndef VADDSUB_CONSTS_VH
`define VADDSUB_CONSTS_VH

// Instruction form codes.
`define FORM_DUAL_HALF 2'h0
`define FORM_QUAD_HALF 2'h1
`define FORM_DUAL_WORD 2'h2
`define FORM_ACCUM     2'h3

// Scaling option codes.
`define SCALE_NONE     2'h0
`define SCALE_HALVE    2'h1
`define SCALE_DOUBLE   2'h2

// Widths.
`define HALF_W         16
`define WORD_W         32
`define ACC_W          40
`define IDX_W          3

`endif

/* addsub_lane.v */
`timescale 1ns/1ps
`include "vaddsub_consts.vh"

// One add/subtract lane with optional scaling and signed saturation.
module addsub_lane #(
   parameter W  = 16,
   parameter RW = 16
) (
   input  wire [W-1:0]  a,
   input  wire [W-1:0]  b,
   input  wire          sub,
   input  wire          sat,
   input  wire [1:0]    scale,
   output reg  [RW-1:0] res,
   output wire          carry,
   output reg           ovf
);
   wire [W:0]   b_eff;
   wire [W:0]   uns;
   wire [W:0]   full;
   reg  [W+1:0] ext;
   wire         fits;
   wire [RW-1:0] maxv;
   wire [RW-1:0] minv;

   // Subtraction is addition of the inverted operand plus one.
   assign b_eff = {1'b0, (sub ? ~b : b)};
   assign uns   = {1'b0, a} + b_eff + {{W{1'b0}}, sub};
   assign carry = uns[W];
   assign full  = sub ? ({a[W-1], a} - {b[W-1], b}) : ({a[W-1], a} + {b[W-1], b});

   always @*
   begin
      case (scale)
         `SCALE_HALVE:  ext = {full[W], full[W], full[W:1]}; // RULE12
         `SCALE_DOUBLE: ext = {full, 1'b0}; // RULE13
         default:       ext = {full[W], full};
      endcase
   end

   // The scaled value fits when the result sign bit and all bits above it agree.
   assign fits = (&ext[W+1:RW-1]) | ~(|ext[W+1:RW-1]);
   assign maxv = {1'b0, {(RW-1){1'b1}}};
   assign minv = {1'b1, {(RW-1){1'b0}}};

   always @*
   begin
      ovf = ~fits; // RULE22
      if (sat && !fits)
         res = ext[W+1] ? minv : maxv; // RULE14
      else
         res = ext[RW-1:0]; // RULE22
   end
endmodule

/* vector_add_subtract_unit.v */
`timescale 1ns/1ps
`include "vaddsub_consts.vh"

// Function
// RULE1: Dual half form adds or subtracts upper and lower halves independently.
// RULE2: Each result goes to its own destination register.
// RULE3: Issuer names two distinct destinations for two-result forms.
// RULE4: Issuer uses one source pair for both operations of paired forms.
// RULE5: Quad form makes two destinations: add/add with sub/sub, or add/sub with sub/add.
// RULE6: Dual word form writes sum and difference, optional 32-bit saturation.
// RULE7: Accumulator form writes sum and difference; form picks subtraction order.
// RULE8: Clamp in dual half form saturates each result to signed 16 bits.
// RULE9: Swap in dual half form exchanges the two half results.
// RULE10: Clamp-and-swap applies both saturation and exchange.
// RULE11: Clamp in other forms saturates at 16 bits for halves, 32 for words.
// RULE12: Halve option shifts each result right arithmetically by one.
// RULE13: Double option shifts each result left by one, truncating.
// RULE14: In quad form scaling happens before saturation.
// RULE15: Scaling only in quad form; swap only in dual half form.
// RULE16: Zero flag set if any result is zero, else cleared.
// RULE17: Negative flag set if any result is negative, else cleared.
// RULE18: Right and left carry flags follow the right and left operations.
// RULE19: Overflow set on any overflow; sticky overflow set with it, else kept.
// RULE20: All other status flags are left unchanged.
// RULE21: Paired issue alongside permitted short instructions is accepted.
// RULE22: Without clamp results wrap; overflow comes from the sign bits.
module vector_add_subtract_unit (
   input  wire        SYS_CLK,
   input  wire        RST_B,
   input  wire        CLK_EN,
   input  wire        ISSUE_VALID,
   input  wire        PAIRED_ISSUE,
   input  wire [1:0]  FORM,
   input  wire [1:0]  OP_SEL,
   input  wire        SAT_EN,
   input  wire        SWAP_EN,
   input  wire [1:0]  SCALE,
   input  wire [31:0] SRC0,
   input  wire [31:0] SRC1,
   input  wire [39:0] ACCUMULATOR_ZERO,
   input  wire [39:0] ACCUMULATOR_ONE,
   input  wire [2:0]  DEST0_IDX,
   input  wire [2:0]  DEST1_IDX,
   output reg  [31:0] RESULT0,
   output reg  [31:0] RESULT1,
   output reg         WR0_EN,
   output reg         WR1_EN,
   output reg  [2:0]  WR0_IDX,
   output reg  [2:0]  WR1_IDX,
   output reg         FLAG_UPDATE,
   output reg         ZERO_RESULT_FLAG,
   output reg         NEGATIVE_RESULT_FLAG,
   output reg         CARRY_RIGHT_FLAG,
   output reg         CARRY_LEFT_FLAG,
   output reg         OVERFLOW_FLAG,
   output reg         STICKY_SUM_TOO_LARGE,
   output reg         PAIRED_DONE,
   output reg         DEST_CLASH
);
   localparam HW = `HALF_W;
   localparam WW = `WORD_W;
   localparam AW = `ACC_W;

   wire            is_dual;
   wire            is_quad;
   wire            is_word;
   wire            is_acc;
   wire            two_dest;
   wire            do_sat;
   wire            do_swap;
   wire [1:0]      half_scale;
   reg  [3:0]      half_sub;
   wire [HW-1:0]   half_res  [0:3];
   wire [3:0]      half_carry;
   wire [3:0]      half_ovf;
   wire [AW-1:0]   wa;
   wire [AW-1:0]   wb;
   wire [WW-1:0]   wide_res  [0:1];
   wire [1:0]      wide_carry;
   wire [1:0]      wide_ovf;
   wire [WW:0]     word_sum;
   wire [WW:0]     word_dif;
   wire            go;

   reg  [WW-1:0]   r0_nxt;
   reg  [WW-1:0]   r1_nxt;
   reg             z_nxt;
   reg             n_nxt;
   reg             cr_nxt;
   reg             cl_nxt;
   reg             v_nxt;

   assign go       = CLK_EN & ISSUE_VALID;
   assign is_dual  = (FORM == `FORM_DUAL_HALF);
   assign is_quad  = (FORM == `FORM_QUAD_HALF);
   assign is_word  = (FORM == `FORM_DUAL_WORD);
   assign is_acc   = (FORM == `FORM_ACCUM);
   assign two_dest = ~is_dual;
   assign do_sat   = SAT_EN; // RULE8 RULE11
   assign do_swap  = is_dual & SWAP_EN; // RULE15
   assign half_scale = is_quad ? SCALE : `SCALE_NONE; // RULE15

   // Lane order: 0 dest0 low, 1 dest0 high, 2 dest1 low, 3 dest1 high.
   // Dual half: OP_SEL[1] selects the high operation, OP_SEL[0] the low.
   // Quad: OP_SEL[0] low gives add/add and sub/sub, high gives add/sub and sub/add.
   always @*
   begin
      case (FORM)
         `FORM_DUAL_HALF:
         begin
            half_sub = {1'b1, ~OP_SEL[0], OP_SEL[1], OP_SEL[0]}; // RULE1
         end
         `FORM_QUAD_HALF:
         begin
            half_sub = {1'b1, ~OP_SEL[0], 1'b0, OP_SEL[0]}; // RULE5
         end
         default:
         begin
            half_sub = {1'b1, ~OP_SEL[0], 1'b0, OP_SEL[0]};
         end
      endcase
   end

   // Both results of a pair share one operand pair: SRC0 and SRC1, or the two accumulators in accumulator form.
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1)
      begin : g_half
         addsub_lane #(
            .W  (HW),
            .RW (HW)
         ) u_lane (
            .a     (SRC0[(k%2)*HW +: HW]), // RULE4
            .b     (SRC1[(k%2)*HW +: HW]), // RULE4
            .sub   (half_sub[k]),
            .sat   (do_sat),
            .scale (half_scale),
            .res   (half_res[k]),
            .carry (half_carry[k]),
            .ovf   (half_ovf[k])
         );
      end
   endgenerate

   // Wide operands: sign-extended words, or accumulators in chosen order.
   assign wa = is_acc ? (OP_SEL[0] ? ACCUMULATOR_ZERO : ACCUMULATOR_ONE)
                      : {{(AW-WW){SRC0[WW-1]}}, SRC0}; // RULE7
   assign wb = is_acc ? (OP_SEL[0] ? ACCUMULATOR_ONE : ACCUMULATOR_ZERO)
                      : {{(AW-WW){SRC1[WW-1]}}, SRC1}; // RULE7

   generate
      for (k = 0; k < 2; k = k + 1)
      begin : g_wide
         addsub_lane #(
            .W  (AW),
            .RW (WW)
         ) u_lane (
            .a     (wa),
            .b     (wb),
            .sub   (k == 1),
            .sat   (do_sat),
            .scale (`SCALE_NONE),
            .res   (wide_res[k]),
            .carry (wide_carry[k]),
            .ovf   (wide_ovf[k])
         );
      end
   endgenerate

   // Word carries are taken at 32 bits, not from the extended operands.
   assign word_sum = {1'b0, SRC0} + {1'b0, SRC1};
   assign word_dif = {1'b0, SRC0} + {1'b0, ~SRC1} + {{WW{1'b0}}, 1'b1};

   always @*
   begin
      r0_nxt = {half_res[1], half_res[0]};
      r1_nxt = {half_res[3], half_res[2]};
      z_nxt  = 1'b0;
      n_nxt  = 1'b0;
      cr_nxt = 1'b0;
      cl_nxt = 1'b0;
      v_nxt  = 1'b0;
      case (FORM)
         `FORM_DUAL_HALF:
         begin
            if (do_swap)
               r0_nxt = {half_res[0], half_res[1]}; // RULE9 RULE10
            z_nxt  = (half_res[0] == 16'h0000) | (half_res[1] == 16'h0000); // RULE16
            n_nxt  = half_res[0][HW-1] | half_res[1][HW-1]; // RULE17
            cr_nxt = half_carry[0]; // RULE18
            cl_nxt = half_carry[1]; // RULE18
            v_nxt  = half_ovf[0] | half_ovf[1]; // RULE19
         end
         `FORM_QUAD_HALF:
         begin
            z_nxt  = (half_res[0] == 16'h0000) | (half_res[1] == 16'h0000)
                   | (half_res[2] == 16'h0000) | (half_res[3] == 16'h0000); // RULE16
            n_nxt  = half_res[0][HW-1] | half_res[1][HW-1]
                   | half_res[2][HW-1] | half_res[3][HW-1]; // RULE17
            cr_nxt = half_carry[2] | half_carry[3]; // RULE18
            cl_nxt = half_carry[0] | half_carry[1]; // RULE18
            v_nxt  = |half_ovf; // RULE19
         end
         `FORM_DUAL_WORD, `FORM_ACCUM:
         begin
            r0_nxt = wide_res[0]; // RULE6 RULE7
            r1_nxt = wide_res[1]; // RULE6 RULE7
            z_nxt  = (wide_res[0] == 32'h0000_0000)
                   | (wide_res[1] == 32'h0000_0000); // RULE16
            n_nxt  = wide_res[0][WW-1] | wide_res[1][WW-1]; // RULE17
            cr_nxt = is_word ? word_dif[WW] : wide_carry[1]; // RULE18
            cl_nxt = is_word ? word_sum[WW] : wide_carry[0]; // RULE18
            v_nxt  = |wide_ovf; // RULE19
         end
         default:
         begin
            v_nxt  = 1'b0;
         end
      endcase
   end

   // Write strobes and indication pulses stand for one cycle after each issue.
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         WR0_EN      <= 1'b0;
         WR1_EN      <= 1'b0;
         FLAG_UPDATE <= 1'b0;
         PAIRED_DONE <= 1'b0;
         DEST_CLASH  <= 1'b0;
      end
      else if (CLK_EN)
      begin
         WR0_EN      <= ISSUE_VALID; // RULE2
         WR1_EN      <= ISSUE_VALID & two_dest; // RULE2
         FLAG_UPDATE <= ISSUE_VALID; // RULE20
         PAIRED_DONE <= ISSUE_VALID & PAIRED_ISSUE; // RULE21
         DEST_CLASH  <= ISSUE_VALID & two_dest & (DEST0_IDX == DEST1_IDX); // RULE3
      end
   end

   // Results hold until the next taken issue.
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         RESULT0 <= 32'h0000_0000;
         RESULT1 <= 32'h0000_0000;
      end
      else if (go)
      begin
         RESULT0 <= r0_nxt; // RULE2
         RESULT1 <= r1_nxt; // RULE2
      end
   end

   // Destination numbers travel with the results they belong to.
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         WR0_IDX <= 3'h0;
         WR1_IDX <= 3'h0;
      end
      else if (go)
      begin
         WR0_IDX <= DEST0_IDX; // RULE2
         WR1_IDX <= DEST1_IDX; // RULE2
      end
   end

   // The five result flags follow each issue and hold in between.
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ZERO_RESULT_FLAG     <= 1'b0;
         NEGATIVE_RESULT_FLAG <= 1'b0;
         CARRY_RIGHT_FLAG     <= 1'b0;
         CARRY_LEFT_FLAG      <= 1'b0;
         OVERFLOW_FLAG        <= 1'b0;
      end
      else if (go)
      begin
         ZERO_RESULT_FLAG     <= z_nxt; // RULE16
         NEGATIVE_RESULT_FLAG <= n_nxt; // RULE17
         CARRY_RIGHT_FLAG     <= cr_nxt; // RULE18
         CARRY_LEFT_FLAG      <= cl_nxt; // RULE18
         OVERFLOW_FLAG        <= v_nxt; // RULE19
      end
   end

   // Sticky overflow only ever sets here; reset alone clears it.
   always @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         STICKY_SUM_TOO_LARGE <= 1'b0;
      end
      else if (go && v_nxt)
      begin
         STICKY_SUM_TOO_LARGE <= 1'b1; // RULE19
      end
   end
endmodule

/* vaddsub_chk.sv */
`timescale 1ns/1ps
module vaddsub_chk (
   input wire        SYS_CLK,
   input wire        RST_B,
   input wire        CLK_EN,
   input wire        ISSUE_VALID,
   input wire        PAIRED_ISSUE,
   input wire [1:0]  FORM,
   input wire        SAT_EN,
   input wire [31:0] SRC0,
   input wire [31:0] SRC1,
   input wire [2:0]  DEST0_IDX,
   input wire [31:0] RESULT0,
   input wire [31:0] RESULT1,
   input wire        WR0_EN,
   input wire        WR1_EN,
   input wire [2:0]  WR0_IDX,
   input wire        FLAG_UPDATE,
   input wire        ZERO_RESULT_FLAG,
   input wire        NEGATIVE_RESULT_FLAG,
   input wire        OVERFLOW_FLAG,
   input wire        STICKY_SUM_TOO_LARGE,
   input wire        PAIRED_DONE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   sequence taken; CLK_EN && ISSUE_VALID; endsequence
   sequence word_op; taken ##0 FORM == 2'h2; endsequence
   sequence word_clean; word_op ##0 !SAT_EN; endsequence
   write_pulse_a: assert property (taken |=> WR0_EN && FLAG_UPDATE)
      else $error("write pulse missing after issue");
   second_write_a: assert property (taken ##0 FORM != 2'h0 |=> WR1_EN)
      else $error("second write missing");
   single_write_a: assert property (taken ##0 FORM == 2'h0 |=> !WR1_EN)
      else $error("second write in dual half form");
   dest_idx_a: assert property (taken |=> WR0_IDX == $past(DEST0_IDX))
      else $error("wrong destination index");
   word_sum_a: assert property (word_clean |=> RESULT0 == $past(SRC0) + $past(SRC1))
      else $error("word sum wrong");
   word_diff_a: assert property (word_clean |=> RESULT1 == $past(SRC0) - $past(SRC1))
      else $error("word difference wrong");
   word_zero_a: assert property (word_op |=>
      ZERO_RESULT_FLAG == (RESULT0 == 32'h0000_0000 || RESULT1 == 32'h0000_0000))
      else $error("zero flag wrong");
   word_neg_a: assert property (word_op |=>
      NEGATIVE_RESULT_FLAG == (RESULT0[31] | RESULT1[31]))
      else $error("negative flag wrong");
   sticky_follow_a: assert property (OVERFLOW_FLAG |-> STICKY_SUM_TOO_LARGE)
      else $error("sticky flag not set with overflow");
   sticky_keep_a: assert property (!$fell(STICKY_SUM_TOO_LARGE))
      else $error("sticky flag cleared");
   paired_done_a: assert property (taken ##0 PAIRED_ISSUE |=> PAIRED_DONE)
      else $error("paired issue not acknowledged");
endmodule
bind vector_add_subtract_unit vaddsub_chk chk (.*);

/* data_reg_file.sv */
`timescale 1ns/1ps
module data_reg_file (
   input wire        clk,
   input wire        we0,
   input wire        we1,
   input wire [2:0]  idx0,
   input wire [2:0]  idx1,
   input wire [31:0] d0,
   input wire [31:0] d1
);
   reg [31:0] regs [0:7];
   // Both results land in full data registers.
   always @(posedge clk)
   begin
      if (we0)
         regs[idx0] <= d0;
      if (we1)
         regs[idx1] <= d1;
   end
endmodule

/* vector_add_subtract_unit_bench.sv */
`timescale 1ns/1ps
module vector_add_subtract_unit_bench;
   reg         SYS_CLK, RST_B, CLK_EN, ISSUE_VALID, PAIRED_ISSUE, SAT_EN, SWAP_EN;
   reg  [1:0]  FORM, OP_SEL, SCALE, pd;
   reg  [31:0] SRC0, SRC1;
   reg  [39:0] ACCUMULATOR_ZERO, ACCUMULATOR_ONE;
   reg  [2:0]  DEST0_IDX, DEST1_IDX;
   wire [31:0] RESULT0, RESULT1;
   wire [2:0]  WR0_IDX, WR1_IDX;
   wire        WR0_EN, WR1_EN, FLAG_UPDATE, ZERO_RESULT_FLAG, NEGATIVE_RESULT_FLAG;
   wire        CARRY_RIGHT_FLAG, CARRY_LEFT_FLAG, OVERFLOW_FLAG, STICKY_SUM_TOO_LARGE;
   wire        PAIRED_DONE, DEST_CLASH;
   integer     fails, num_checks, cycles, i;
   vector_add_subtract_unit dut (.*);
   data_reg_file rf (.clk(SYS_CLK), .we0(WR0_EN), .we1(WR1_EN), .idx0(WR0_IDX),
      .idx1(WR1_IDX), .d0(RESULT0), .d1(RESULT1));
   task tally_and_finish;
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   // One source pair feeds both operations; control is {clamp, swap, scale}.
   task go(input [1:0] f, input [1:0] op, input [3:0] c, input [31:0] a, input [31:0] b,
           input [31:0] e0, input [31:0] e1);
   begin
      @(posedge SYS_CLK);
      ISSUE_VALID <= 1'h1;
      FORM <= f;
      OP_SEL <= op;
      {SAT_EN, SWAP_EN, SCALE} <= c;
      SRC0 <= a;
      SRC1 <= b;
      @(posedge SYS_CLK);
      ISSUE_VALID <= 1'h0;
      PAIRED_ISSUE <= 1'h0;
      @(negedge SYS_CLK);
      pd = {PAIRED_DONE, DEST_CLASH};
      chk(RESULT0, e0);
      if (f != 2'h0)
         chk(RESULT1, e1);
      @(negedge SYS_CLK);
      chk(rf.regs[DEST0_IDX], e0);
      if (f != 2'h0)
         chk(rf.regs[DEST1_IDX], e1);
   end
   endtask
   initial
   begin
      SYS_CLK = 1'h0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK)
   begin
      cycles = cycles + 1;
      if (cycles == 1000)
      begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   initial
   begin
      {fails, num_checks, cycles, RST_B, ISSUE_VALID, PAIRED_ISSUE} = 0;
      {FORM, OP_SEL, SAT_EN, SWAP_EN, SCALE, SRC0, SRC1} = 0;
      {ACCUMULATOR_ZERO, ACCUMULATOR_ONE} = 0;
      CLK_EN = 1'h1;
      DEST0_IDX = 3'h2;
      DEST1_IDX = 3'h5;
      repeat (10) @(posedge SYS_CLK);
      RST_B <= 1'h1;
      go(2'h2, 2'h0, 4'h0, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFE);
      chk({ZERO_RESULT_FLAG, NEGATIVE_RESULT_FLAG, OVERFLOW_FLAG, STICKY_SUM_TOO_LARGE}, 4'hC);
      chk({CARRY_LEFT_FLAG, CARRY_RIGHT_FLAG}, 2'h3);
      go(2'h2, 2'h0, 4'h8, 32'h7FFF_FFFF, 32'h0000_0001, 32'h7FFF_FFFF, 32'h7FFF_FFFE);
      chk({ZERO_RESULT_FLAG, NEGATIVE_RESULT_FLAG, OVERFLOW_FLAG, STICKY_SUM_TOO_LARGE}, 4'h3);
      for (i = 0; i < 4; i = i + 1)
         go(2'h0, i[1:0], 4'h0, 32'h0010_0008, 32'h0003_0005, {i[1] ? 16'h000D : 16'h0013,
            i[0] ? 16'h0003 : 16'h000D}, 32'h0000_0000);
      chk({ZERO_RESULT_FLAG, NEGATIVE_RESULT_FLAG, OVERFLOW_FLAG, STICKY_SUM_TOO_LARGE}, 4'h1);
      go(2'h0, 2'h1, 4'h8, 32'h7FFF_8000, 32'h0001_0001, 32'h7FFF_8000, 32'h0000_0000);
      go(2'h0, 2'h1, 4'h0, 32'h7FFF_8000, 32'h0001_0001, 32'h8000_7FFF, 32'h0000_0000);
      chk({ZERO_RESULT_FLAG, NEGATIVE_RESULT_FLAG, OVERFLOW_FLAG, STICKY_SUM_TOO_LARGE}, 4'h7);
      go(2'h0, 2'h1, 4'hC, 32'h7FFF_8000, 32'h0001_0001, 32'h8000_7FFF, 32'h0000_0000);
      go(2'h0, 2'h1, 4'h4, 32'h0001_0002, 32'h0003_0004, 32'hFFFE_0004, 32'h0000_0000);
      go(2'h0, 2'h0, 4'h1, 32'h0010_0008, 32'h0003_0005, 32'h0013_000D, 32'h0000_0000);
      go(2'h1, 2'h0, 4'h0, 32'h0010_0008, 32'h0003_0005, 32'h0013_000D, 32'h000D_0003);
      go(2'h1, 2'h1, 4'h0, 32'h0010_0008, 32'h0003_0005, 32'h0013_0003, 32'h000D_000D);
      go(2'h1, 2'h0, 4'h3, 32'h0010_0008, 32'h0003_0005, 32'h0013_000D, 32'h000D_0003);
      go(2'h1, 2'h0, 4'h5, 32'h0010_0008, 32'h0003_0005, 32'h0009_0006, 32'h0006_0001);
      go(2'h1, 2'h0, 4'h2, 32'h0010_0008, 32'h0003_0005, 32'h0026_001A, 32'h001A_0006);
      go(2'h1, 2'h0, 4'hA, 32'h4000_0000, 32'h0001_0000, 32'h7FFF_0000, 32'h7FFE_0000);
      chk(ZERO_RESULT_FLAG, 1'h1);
      @(posedge SYS_CLK);
      RST_B <= 1'h0;
      @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk({STICKY_SUM_TOO_LARGE, OVERFLOW_FLAG, WR0_EN, FLAG_UPDATE}, 4'h0);
      chk(RESULT0, 32'h0000_0000);
      @(posedge SYS_CLK);
      RST_B <= 1'h1;
      @(posedge SYS_CLK);
      ACCUMULATOR_ONE <= 40'h00_0000_0010;
      ACCUMULATOR_ZERO <= 40'h00_0000_0003;
      go(2'h3, 2'h0, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0013, 32'h0000_000D);
      go(2'h3, 2'h1, 4'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_0013, 32'hFFFF_FFF3);
      @(posedge SYS_CLK);
      ACCUMULATOR_ONE <= 40'h00_7FFF_FFFF;
      ACCUMULATOR_ZERO <= 40'h00_0000_0001;
      go(2'h3, 2'h0, 4'h8, 32'h0000_0000, 32'h0000_0000, 32'h7FFF_FFFF, 32'h7FFF_FFFE);
      @(posedge SYS_CLK);
      CLK_EN <= 1'h0;
      ISSUE_VALID <= 1'h1;
      FORM <= 2'h2;
      SAT_EN <= 1'h0;
      SRC0 <= 32'h0000_0001;
      SRC1 <= 32'h0000_0001;
      repeat (2) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      chk({WR0_EN, FLAG_UPDATE}, 2'h0);
      chk(RESULT0, 32'h7FFF_FFFF);
      @(posedge SYS_CLK);
      CLK_EN <= 1'h1;
      @(posedge SYS_CLK);
      ISSUE_VALID <= 1'h0;
      @(negedge SYS_CLK);
      chk(RESULT0, 32'h0000_0002);
      chk(RESULT1, 32'h0000_0000);
      @(posedge SYS_CLK);
      PAIRED_ISSUE <= 1'h1;
      DEST1_IDX <= 3'h2;
      go(2'h1, 2'h0, 4'h0, 32'h0005_0003, 32'h0000_0000, 32'h0005_0003, 32'h0005_0003);
      chk(pd, 2'h3);
      tally_and_finish;
   end
endmodule
